// *** rtl/ecir_consts.vh ***
// constants for the card information register bank
// assumes inclusion by bare name from the design files under rtl/
`ifndef ECIR_CONSTS_VH
`define ECIR_CONSTS_VH

// ==========================================================
// clock and timing
`define ECIR_CLK_MHZ            40
`define ECIR_PWRUP_TIME_US      1000
`define ECIR_PWRUP_CYCLES       20'h09C40
`define ECIR_NCR_CYCLES         2'h2

// ==========================================================
// command frame layout
`define ECIR_CMD_FRAME_BITS     6'h30
`define ECIR_CMD_LAST_BIT       6'h2F
`define ECIR_CMD_DIR_POS        46
`define ECIR_CMD_IDX_HI         45
`define ECIR_CMD_IDX_LO         40
`define ECIR_CMD_SEND_OP_COND   6'h01
`define ECIR_CMD_ALL_SEND_ID    6'h02
`define ECIR_CMD_SEND_SPECIFIC  6'h09

// ==========================================================
// response frame layout
`define ECIR_RESP_W             136
`define ECIR_RESP_SHORT_LEN     8'h30
`define ECIR_RESP_LONG_LEN      8'h88
`define ECIR_RESP_HDR_SHORT     8'h3F
`define ECIR_RESP_HDR_LONG      8'h3F
`define ECIR_RESP_SHORT_CRC     7'h7F
`define ECIR_RESP_PAD           88'h0

// ==========================================================
// operating conditions word
`define ECIR_OCR_ACCESS_MODE    2'h2
`define ECIR_OCR_RSVD_HI        5'h00
`define ECIR_OCR_WIN_HIGH       9'h1FF
`define ECIR_OCR_WIN_MID        7'h00
`define ECIR_OCR_WIN_LOW        1'b1
`define ECIR_OCR_RSVD_LO        7'h00

// ==========================================================
// identification word
`define ECIR_CID_RSVD           6'h00
`define ECIR_CID_CRC_HI         127
`define ECIR_CID_CRC_LO         8
`define ECIR_CID_CRC_W          120
`define ECIR_FIXED_ONE          1'b1

// ==========================================================
// card specific data word
`define ECIR_STRUCTURE_VERSION      2'h3
`define ECIR_CSD_SPEC_VERSION      4'h4
`define ECIR_CSD_RSVD_121       2'h0
`define ECIR_CSD_ASYNC_TIME     8'h4F
`define ECIR_CSD_CLOCKED_TIME   8'h01
`define ECIR_CSD_BUS_SPEED      8'h32
`define ECIR_CSD_CMD_CLASSES    12'h0F5
`define ECIR_CSD_RD_BLK_LEN     4'h9
`define ECIR_CSD_RD_PARTIAL     1'b0
`define ECIR_CSD_WR_MISALIGN    1'b0
`define ECIR_CSD_RD_MISALIGN    1'b0
`define ECIR_CSD_DSR_IMP        1'b0
`define ECIR_CSD_RSVD_75        2'h0
`define ECIR_CSD_SIZE           12'hFFF
`define ECIR_CSD_CURRENT        3'h7
`define ECIR_CSD_CAP_MULT       3'h7
`define ECIR_CSD_ERASE_SIZE     5'h1F
`define ECIR_CSD_ERASE_MULT     5'h1F
`define ECIR_CSD_PROT_SIZE      5'h0F
`define ECIR_CSD_PROT_ENABLE    1'b1
`define ECIR_CSD_DEFAULT_ECC    2'h0
`define ECIR_CSD_R2W_FACTOR     3'h2
`define ECIR_CSD_WR_BLK_LEN     4'h9
`define ECIR_CSD_WR_PARTIAL     1'b0
`define ECIR_CSD_RSVD_20        4'h0
`define ECIR_CSD_FLAGS_16       9'h000
`define ECIR_CSD_CRC            7'h30

`endif

// *** rtl/ecir_crc7.v ***
// registered CRC7 (x^7 + x^3 + 1) over a parallel word, msb first
// assumes the data input is static or changes slowly against the clock
module ecir_crc7 #(
    parameter DATA_W = 120
) (
    input  wire              ref_clk_i,
    input  wire              rst_i,
    input  wire [DATA_W-1:0] data_i,
    output reg  [6:0]        crc_o
);

    reg [6:0] crc_d;
    reg       fb;
    integer   i;

    // ======================================================
    // bit-serial division unrolled by the loop
    always @* begin
        crc_d = 7'h00;
        fb    = 1'b0;
        for (i = DATA_W - 1; i >= 0; i = i - 1) begin
            fb    = data_i[i] ^ crc_d[6];
            crc_d = {crc_d[5:3], crc_d[2] ^ fb, crc_d[1:0], fb};
        end
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            crc_o <= 7'h00;
        end else begin
            crc_o <= crc_d;
        end
    end

endmodule

// *** rtl/ecir_shifter.v ***
// response shifter: loads a left-aligned frame, sends it msb first
// assumes shift_i pulses once per bus clock falling edge
module ecir_shifter #(
    parameter DATA_W = 136
) (
    input  wire              ref_clk_i,
    input  wire              rst_i,
    input  wire              load_i,
    input  wire [DATA_W-1:0] load_data_i,
    input  wire [7:0]        load_len_i,
    input  wire              shift_i,
    output reg               bit_o,
    output reg               drive_o,
    output wire              busy_o
);

    reg [DATA_W-1:0] data_q;
    reg [7:0]        cnt_q;

    assign busy_o = (cnt_q != 8'h00) | drive_o;

    // ======================================================
    // load and shift
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_q  <= {DATA_W{1'b0}};
            cnt_q   <= 8'h00;
            bit_o   <= 1'b1;
            drive_o <= 1'b0;
        end else if (load_i) begin
            data_q  <= load_data_i;
            cnt_q   <= load_len_i;
            drive_o <= 1'b0;
        end else if (shift_i) begin
            if (cnt_q != 8'h00) begin
                bit_o   <= data_q[DATA_W-1];
                data_q  <= {data_q[DATA_W-2:0], 1'b0};
                cnt_q   <= cnt_q - 8'h01;
                drive_o <= 1'b1;
            end else begin
                bit_o   <= 1'b1;
                drive_o <= 1'b0;
            end
        end
    end

endmodule

// *** rtl/ecir_top.v ***
// card information register bank with its command line responder
// assumes bus clock and command line arrive as pins, asynchronous to ref_clk_i
`include "ecir_consts.vh"

module ecir_top #(
    parameter [19:0] PWRUP_CYCLES = `ECIR_PWRUP_CYCLES,
    parameter [7:0]  MAKER_CODE   = 8'hA5,          // arbitrary value
    parameter [1:0]  PACKAGE_TYPE = 2'h2,           // arbitrary value
    parameter [7:0]  OEM_CODE     = 8'h3C,          // arbitrary value
    parameter [47:0] PRODUCT_NAME = 48'h4543_4952_3031, // arbitrary value
    parameter [7:0]  PRODUCT_REV  = 8'h11,          // arbitrary value
    parameter [31:0] SERIAL_NUM   = 32'h1234_5678,  // arbitrary value
    parameter [7:0]  MFG_DATE     = 8'h00           // arbitrary value
) (
    input  wire ref_clk_i,
    input  wire rst_i,
    input  wire bus_clk_i,
    input  wire cmd_i,
    output wire cmd_o,
    output wire cmd_oe_o,
    output reg  power_up_done_o
);

    // ======================================================
    // states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RECV = 4'h2;
    localparam [3:0] ST_WAIT = 4'h4;
    localparam [3:0] ST_SEND = 4'h8;

    // ======================================================
    // declarations
    reg  [2:0]   bclk_sync_q;
    reg  [2:0]   cmd_sync_q;
    reg          bclk_q;
    reg          cmd_q;
    wire         bclk_rise;
    wire         bclk_fall;
    reg  [19:0]  pwr_cnt_q;
    reg  [3:0]   state_q;
    reg  [3:0]   state_d;
    reg  [47:0]  rx_q;
    reg  [5:0]   rx_cnt_q;
    wire [47:0]  frame;
    wire [5:0]   cmd_index;
    wire         frame_ok;
    reg  [1:0]   wait_q;
    wire [31:0]  op_cond_word;
    wire [127:0] ident_raw;
    wire [127:0] ident_word;
    wire [127:0] specific_word;
    wire [6:0]   ident_crc;
    reg  [`ECIR_RESP_W-1:0] resp_data;
    reg  [7:0]   resp_len;
    reg          resp_known;
    wire         load;
    wire         shift;
    wire         tx_busy;

    // ======================================================
    // pin synchronisers, three stages, change taken when last two agree
    // reset levels match idle pins, so no false edge follows reset
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bclk_sync_q <= 3'h0;
            cmd_sync_q  <= 3'h7;
            bclk_q      <= 1'b0;
            cmd_q       <= 1'b1;
        end else begin
            bclk_sync_q <= {bclk_sync_q[1:0], bus_clk_i};
            cmd_sync_q  <= {cmd_sync_q[1:0], cmd_i};
            if (bclk_sync_q[1] == bclk_sync_q[2]) begin
                bclk_q <= bclk_sync_q[2];
            end
            if (cmd_sync_q[1] == cmd_sync_q[2]) begin
                cmd_q <= cmd_sync_q[2];
            end
        end
    end

    assign bclk_rise = (bclk_sync_q[1] == bclk_sync_q[2]) & bclk_sync_q[2] & ~bclk_q;
    assign bclk_fall = (bclk_sync_q[1] == bclk_sync_q[2]) & ~bclk_sync_q[2] & bclk_q;

    // ======================================================
    // power-up routine timer
    // sticky until the next reset; drives the ready bit
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_cnt_q       <= 20'h00000;
            power_up_done_o <= 1'b0;
        end else if (!power_up_done_o) begin
            pwr_cnt_q <= pwr_cnt_q + 20'h00001;
            // done shows PWRUP_CYCLES clocks after release
            if (pwr_cnt_q >= PWRUP_CYCLES - 20'h00001) begin
                power_up_done_o <= 1'b1;
            end
        end
    end

    // ======================================================
    // register contents
    assign op_cond_word = {power_up_done_o,
                           `ECIR_OCR_ACCESS_MODE,
                           `ECIR_OCR_RSVD_HI,
                           `ECIR_OCR_WIN_HIGH,
                           `ECIR_OCR_WIN_MID,
                           `ECIR_OCR_WIN_LOW,
                           `ECIR_OCR_RSVD_LO};

    assign ident_raw = {MAKER_CODE, `ECIR_CID_RSVD, PACKAGE_TYPE, OEM_CODE,
                        PRODUCT_NAME, PRODUCT_REV, SERIAL_NUM, MFG_DATE,
                        7'h00, `ECIR_FIXED_ONE};

    // constant fields: crc settles one clock after reset
    ecir_crc7 #(
        .DATA_W (`ECIR_CID_CRC_W)
    ) u_ident_crc (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .data_i    (ident_raw[`ECIR_CID_CRC_HI:`ECIR_CID_CRC_LO]),
        .crc_o     (ident_crc)
    );

    // crc replaces bits 7:1, bit 0 fixed one
    assign ident_word = {ident_raw[127:8], ident_crc, `ECIR_FIXED_ONE};

    // all constant; checksum field is fixed, not computed
    assign specific_word = {`ECIR_STRUCTURE_VERSION,
                            `ECIR_CSD_SPEC_VERSION,
                            `ECIR_CSD_RSVD_121,
                            `ECIR_CSD_ASYNC_TIME,
                            `ECIR_CSD_CLOCKED_TIME,
                            `ECIR_CSD_BUS_SPEED,
                            `ECIR_CSD_CMD_CLASSES,
                            `ECIR_CSD_RD_BLK_LEN,
                            `ECIR_CSD_RD_PARTIAL,
                            `ECIR_CSD_WR_MISALIGN,
                            `ECIR_CSD_RD_MISALIGN,
                            `ECIR_CSD_DSR_IMP,
                            `ECIR_CSD_RSVD_75,
                            `ECIR_CSD_SIZE,
                            `ECIR_CSD_CURRENT,
                            `ECIR_CSD_CURRENT,
                            `ECIR_CSD_CURRENT,
                            `ECIR_CSD_CURRENT,
                            `ECIR_CSD_CAP_MULT,
                            `ECIR_CSD_ERASE_SIZE,
                            `ECIR_CSD_ERASE_MULT,
                            `ECIR_CSD_PROT_SIZE,
                            `ECIR_CSD_PROT_ENABLE,
                            `ECIR_CSD_DEFAULT_ECC,
                            `ECIR_CSD_R2W_FACTOR,
                            `ECIR_CSD_WR_BLK_LEN,
                            `ECIR_CSD_WR_PARTIAL,
                            `ECIR_CSD_RSVD_20,
                            `ECIR_CSD_FLAGS_16,
                            `ECIR_CSD_CRC,
                            `ECIR_FIXED_ONE};

    // ======================================================
    // command frame capture on bus clock rising edges
    // start bit is not shifted in; rx_q[46] stays zero in its place
    // command argument and crc are taken but not checked
    assign frame     = {rx_q[46:0], cmd_q};
    assign cmd_index = frame[`ECIR_CMD_IDX_HI:`ECIR_CMD_IDX_LO];
    assign frame_ok  = frame[`ECIR_CMD_DIR_POS] & frame[0];

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_q     <= 48'h0;
            rx_cnt_q <= 6'h00;
        end else if (bclk_rise) begin
            if (state_q == ST_IDLE && !cmd_q) begin
                rx_q     <= 48'h0;
                rx_cnt_q <= 6'h01;
            end else if (state_q == ST_RECV) begin
                rx_q     <= frame;
                rx_cnt_q <= rx_cnt_q + 6'h01;
            end
        end
    end

    // ======================================================
    // response selection, start and transmission bits, msb first
    always @* begin
        resp_data  = {`ECIR_RESP_W{1'b0}};
        resp_len   = 8'h00;
        resp_known = 1'b0;
        case (cmd_index)
            // short frame: crc field reads all ones, pad never sent
            `ECIR_CMD_SEND_OP_COND: begin
                resp_data  = {`ECIR_RESP_HDR_SHORT, op_cond_word,
                              `ECIR_RESP_SHORT_CRC, 1'b1, `ECIR_RESP_PAD};
                resp_len   = `ECIR_RESP_SHORT_LEN;
                resp_known = 1'b1;
            end
            // long frames: word bit 0 gives way to the end bit
            `ECIR_CMD_ALL_SEND_ID: begin
                resp_data  = {`ECIR_RESP_HDR_LONG, ident_word[127:1], 1'b1};
                resp_len   = `ECIR_RESP_LONG_LEN;
                resp_known = 1'b1;
            end
            `ECIR_CMD_SEND_SPECIFIC: begin
                resp_data  = {`ECIR_RESP_HDR_LONG, specific_word[127:1], 1'b1};
                resp_len   = `ECIR_RESP_LONG_LEN;
                resp_known = 1'b1;
            end
            // other index: no response
            default: begin
                resp_known = 1'b0;
            end
        endcase
    end

    // ======================================================
    // sequencer
    // receiver ignores the line while waiting or sending
    // first response bit leaves on the third falling edge after the end bit
    assign load  = (state_q == ST_RECV) & bclk_rise &
                   (rx_cnt_q == `ECIR_CMD_LAST_BIT) & frame_ok & resp_known;
    assign shift = (state_q == ST_SEND) & bclk_fall;

    always @* begin
        state_d = state_q;
        case (state_q)
            // low line at a rising edge opens a frame
            ST_IDLE: begin
                if (bclk_rise && !cmd_q) begin
                    state_d = ST_RECV;
                end
            end
            // bad direction, end bit or index: back to idle
            ST_RECV: begin
                if (bclk_rise && rx_cnt_q == `ECIR_CMD_LAST_BIT) begin
                    state_d = load ? ST_WAIT : ST_IDLE;
                end
            end
            // two bus clocks of turnaround
            ST_WAIT: begin
                if (bclk_fall && wait_q == `ECIR_NCR_CYCLES - 2'h1) begin
                    state_d = ST_SEND;
                end
            end
            // idle again once the shifter lets go
            ST_SEND: begin
                if (!tx_busy) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            wait_q  <= 2'h0;
        end else begin
            state_q <= state_d;
            // counts falling edges only while waiting
            if (state_q != ST_WAIT) begin
                wait_q <= 2'h0;
            end else if (bclk_fall) begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end

    // output enable high only while the shifter drives
    ecir_shifter #(
        .DATA_W (`ECIR_RESP_W)
    ) u_shifter (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .load_i      (load),
        .load_data_i (resp_data),
        .load_len_i  (resp_len),
        .shift_i     (shift),
        .bit_o       (cmd_o),
        .drive_o     (cmd_oe_o),
        .busy_o      (tx_busy)
    );

endmodule

// *** test/ecir_top_assertions.sv ***
// checker for the card information register bank, bound to ecir_top
// assumes the bus clock low phase spans at least 8 reference clocks
module ecir_top_assertions #(
    parameter [19:0] PWRUP_CYCLES = 20'h09C40
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic bus_clk_i,
    input wire logic cmd_i,
    input wire logic cmd_o,
    input wire logic cmd_oe_o,
    input wire logic power_up_done_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // helper counters
    logic [20:0] cnt_q;
    logic [7:0]  fall_q;
    logic        bus_q;

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= 21'h000000;
            fall_q <= 8'h00;
            bus_q  <= 1'b0;
        end else begin
            bus_q <= bus_clk_i;
            if (cnt_q < {1'b0, PWRUP_CYCLES} + 21'h4)
                cnt_q <= cnt_q + 21'h1;
            if (!cmd_oe_o)
                fall_q <= 8'h00;
            else if (bus_q && !bus_clk_i)
                fall_q <= fall_q + 8'h01;
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_resp_start;
        $rose(cmd_oe_o);
    endsequence
    sequence s_lead_zeros;
        (cmd_oe_o && !cmd_o)[*8];
    endsequence

    a_reset_idle: assert property ($fell(rst_i) |-> cmd_o && !cmd_oe_o && !power_up_done_o)
        else $error("outputs not idle after reset");
    a_done_holds: assert property (power_up_done_o |=> power_up_done_o)
        else $error("ready flag dropped");
    a_done_moment: assert property ($rose(power_up_done_o) |->
        (cnt_q >= {1'b0, PWRUP_CYCLES}) && (cnt_q <= {1'b0, PWRUP_CYCLES} + 21'h1))
        else $error("ready flag rose at wrong cycle");
    a_done_late: assert property (cnt_q == {1'b0, PWRUP_CYCLES} + 21'h2 |-> power_up_done_o)
        else $error("ready flag missing after power up");
    a_idle_high: assert property (!cmd_oe_o |-> cmd_o)
        else $error("command output not high while released");
    a_lead_zero: assert property (s_resp_start |-> s_lead_zeros)
        else $error("response does not open with zero bits");
    a_bit_on_fall: assert property ($changed(cmd_o) && $past(cmd_oe_o) |-> !bus_clk_i)
        else $error("response bit changed while bus clock high");
    a_frame_length: assert property ($fell(cmd_oe_o) |-> fall_q == 8'h30 || fall_q == 8'h88)
        else $error("response frame length wrong");
endmodule

bind ecir_top ecir_top_assertions #(.PWRUP_CYCLES(PWRUP_CYCLES)) i_ecir_top_assertions (
    .ref_clk_i      (ref_clk_i),
    .rst_i          (rst_i),
    .bus_clk_i      (bus_clk_i),
    .cmd_i          (cmd_i),
    .cmd_o          (cmd_o),
    .cmd_oe_o       (cmd_oe_o),
    .power_up_done_o(power_up_done_o)
);

// *** test/ecir_host_model.sv ***
// host controller model: sends command frames, collects responses
// assumes the command line is resolved outside by a mux that passes the device output while it is enabled
module ecir_host_model (
    input  wire logic ref_clk_i,
    input  wire logic dev_cmd_i,
    input  wire logic dev_oe_i,
    output logic      bus_clk_o,
    output logic      cmd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_clk_o = 1'b0;
        cmd_o     = 1'b1;
    end

    // ==========================================================
    // half a bus clock period
    task automatic half();
        repeat (8) @(posedge ref_clk_i);
    endtask

    // bus clock stands low between frames
    task automatic transact(input logic [47:0] frame, input int len,
                            output logic [135:0] resp, output int nbits);
        resp  = '0;
        nbits = 0;
        for (int i = 47; i >= 0; i--) begin
            cmd_o <= frame[i];
            half();
            bus_clk_o <= 1'b1;
            half();
            bus_clk_o <= 1'b0;
        end
        cmd_o <= 1'b1;
        for (int i = 0; i < len + 8; i++) begin
            half();
            bus_clk_o <= 1'b1;
            if (dev_oe_i) begin
                resp  = {resp[134:0], dev_cmd_i};
                nbits = nbits + 1;
            end
            half();
            bus_clk_o <= 1'b0;
        end
    endtask
endmodule

// *** test/ecir_top_tb.sv ***
// self-checking bench for the card information register bank
// assumes a host model on the command line, muxed with the device output by cmd_oe_o
module ecir_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam [19:0]  PWR    = 20'h007D0;
    localparam [7:0]   MAKER  = 8'h6B;              // arbitrary value
    localparam [1:0]   PKG    = 2'h2;               // arbitrary value
    localparam [7:0]   OEM    = 8'h27;              // arbitrary value
    localparam [47:0]  NAME   = 48'h5445_5354_4E4D; // arbitrary value
    localparam [7:0]   REV    = 8'h42;              // arbitrary value
    localparam [31:0]  SERIAL = 32'hC0DE_0917;      // arbitrary value
    localparam [7:0]   DATE   = 8'h93;              // arbitrary value

    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    wire         bus_clk;
    wire         host_cmd;
    wire         cmd_o;
    wire         cmd_oe_o;
    wire         done;
    wire         cmd_line;
    int          errors      = 0;
    int          check_count = 0;
    int          cycles      = 0;
    logic [31:0] seed        = 32'hBAB5;
    logic [5:0]  idx;

    always #12.5 ref_clk_i = ~ref_clk_i;
    assign cmd_line = cmd_oe_o ? cmd_o : host_cmd;

    ecir_top #(.PWRUP_CYCLES(PWR), .MAKER_CODE(MAKER), .PACKAGE_TYPE(PKG), .OEM_CODE(OEM),
        .PRODUCT_NAME(NAME), .PRODUCT_REV(REV), .SERIAL_NUM(SERIAL), .MFG_DATE(DATE)) i_ecir_top (
        .ref_clk_i      (ref_clk_i),
        .rst_i          (rst_i),
        .bus_clk_i      (bus_clk),
        .cmd_i          (cmd_line),
        .cmd_o          (cmd_o),
        .cmd_oe_o       (cmd_oe_o),
        .power_up_done_o(done)
    );

    ecir_host_model i_ecir_host_model (
        .ref_clk_i(ref_clk_i),
        .dev_cmd_i(cmd_line),
        .dev_oe_i (cmd_oe_o),
        .bus_clk_o(bus_clk),
        .cmd_o    (host_cmd)
    );

    // ==========================================================
    // reference model
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [6:0] crc7(input logic [119:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 119; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction

    function automatic logic [135:0] op_frame(input logic rdy);
        return {88'h0, 8'h3F, rdy, 2'b10, 5'h00, 9'h1FF, 7'h00, 1'b1, 7'h00, 8'hFF};
    endfunction

    function automatic logic [135:0] ident_frame();
        logic [119:0] id;
        id = {MAKER, 6'h00, PKG, OEM, NAME, REV, SERIAL, DATE};
        return {8'h3F, id, crc7(id), 1'b1};
    endfunction

    function automatic logic [135:0] spec_frame();
        return {8'h3F, 2'h3, 4'h4, 2'h0, 8'h4F, 8'h01, 8'h32, 12'h0F5, 4'h9, 4'h0, 2'h0,
                12'hFFF, 15'h7FFF, 5'h1F, 5'h1F, 5'h0F, 1'b1, 2'h0, 3'h2, 4'h9,
                14'h0000, 7'h30, 1'b1};
    endfunction

    // ==========================================================
    // checking and stimulus tasks
    task automatic check(input logic [135:0] seen, input logic [135:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic run(input string name, input logic [5:0] ix, input logic dir,
                       input logic endb, input int len, input logic [135:0] exp);
        logic [135:0] r;
        int           n;
        logic [31:0]  a;
        logic [31:0]  c;
        a = xs();
        c = xs();
        i_ecir_host_model.transact({1'b0, dir, ix, a, c[6:0], endb}, len, r, n);
        check(r, exp);
        check(136'(n), 136'(len));
        $display("test %s done", name);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            stop_test();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        check(136'(done), 136'h0);
        run("op_busy", 6'h01, 1'b1, 1'b1, 48, op_frame(1'b0));
        for (int i = 0; i < 3000 && done !== 1'b1; i++)
            @(posedge ref_clk_i);
        check(136'(done), 136'h1);
        run("op_ready", 6'h01, 1'b1, 1'b1, 48, op_frame(1'b1));
        run("ident", 6'h02, 1'b1, 1'b1, 136, ident_frame());
        run("spec", 6'h09, 1'b1, 1'b1, 136, spec_frame());
        run("spec_again", 6'h09, 1'b1, 1'b1, 136, spec_frame());
        run("bad_dir", 6'h01, 1'b0, 1'b1, 0, 136'h0);
        run("bad_end", 6'h02, 1'b1, 1'b0, 0, 136'h0);
        for (int i = 0; i < 3; i++) begin
            idx = 6'(xs());
            if (idx == 6'h01 || idx == 6'h02 || idx == 6'h09)
                idx = idx ^ 6'h20;
            run("bad_index", idx, 1'b1, 1'b1, 0, 136'h0);
        end
        stop_test();
    end
endmodule
